//--- core/cpw_unit.sv
// Capture, compare and pulse-width unit with an AXI4-Lite register slave.
// Function
// RULE1 - Mode 0000 turns the unit off and holds it in reset; 0001, 0011 do nothing.
// RULE2 - Capture on falling, rising, every fourth or every sixteenth rising edge.
// RULE3 - Compare match toggles, sets or clears the output and raises the unit flag.
// RULE4 - Mode 1010 match only raises the unit flag; the pin stays.
// RULE5 - Mode 1011 match raises flag, resets timer one, starts conversion if enabled.
// RULE6 - Modes 110x give active-high pulse output, 111x active-low.
// RULE7 - Capture copies the whole 16-bit timer-one count into both result bytes.
// RULE8 - Capture sets the unit flag at bit 5; only software clears it.
// RULE9 - A newer capture overwrites an unread result.
// RULE10 - With the pin driven as output, port data writes can cause captures.
// RULE11 - The edge prescaler clears when off, outside capture modes and on reset.
// RULE12 - Changing between capture prescale settings keeps the prescaler count.
// RULE13 - Compare checks result against timer one each cycle; action and flag together.
// RULE14 - Writing zero to control forces the compare output latch low.
// RULE15 - Special trigger fires at once; timer-one reset waits for its next clock edge.
// RULE16 - A special-trigger reset of timer one never sets the overflow flag.
// RULE17 - If the match disappears before that edge, the timer-one reset is skipped.
// RULE18 - Software runs timer one in timer or synchronized counter mode.
// RULE19 - Pulse mode gives up to 10-bit duty, timed by timer two.
// RULE20 - Clearing control forces the pulse latch inactive; port latch untouched.
// RULE21 - Control bits 5:4 are duty low bits, low result byte holds high eight.
// RULE22 - Control bits 7:6 read as zero.
// RULE23 - On period match increment: set output unless duty zero, latch duty.
// RULE24 - Output clears when latched duty equals timer two with two phase bits.
// RULE25 - Capture pin is synchronised and edges found before the prescaler.
//
// Local design decision: the AXI4-Lite register port.
`include "cpw_defines.svh"
module cpw_unit (
  input wire logic ref_clk_in,
  input wire logic sys_rst_in,
  // AXI4-Lite slave.
  input wire logic [11:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic [11:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  // Timer one.
  input wire logic [15:0] timer_one_in,
  input wire logic timer_one_tick_in,
  input wire logic timer_one_overflow_in,
  output logic timer_one_reset_out,
  // Timer two.
  input wire logic [7:0] timer_two_in,
  input wire logic [1:0] timer_two_phase_in,
  input wire logic timer_two_tick_in,
  input wire logic [7:0] period_register_in,
  // Converter and port.
  input wire logic adc_enabled_in,
  output logic adc_start_out,
  output logic special_event_out,
  input wire logic port_direction_in,
  input wire logic port_data_in,
  input wire logic unit_pin_in,
  output logic unit_pin_out,
  output logic unit_pin_oe_n_out,
  output logic unit_flag_out
);
  // Software-visible registers, unit state and bus state.
  logic [7:0] res_low_q, res_high_q;
  logic [5:0] control_q;
  logic [3:0] presc_q;
  logic [1:0] duty_lsb_latch_q, bresp_q, rresp_q;
  logic [11:0] awaddr_q;
  logic [31:0] wdata_q, rdata_q;
  logic unit_flag_q, t1_ovf_flag_q, sync1_q, sync2_q, sync3_q, pin_filt_q, cap_level_q;
  logic match_q, pending_reset_q, cmp_latch_q, pwm_latch_q, aw_have_q, w_have_q, wstrb0_q;
  logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
  // Unit outputs.
  logic t1_reset_q, adc_start_q, special_q, pin_out_q, pin_oe_n_q;
  // Decoded mode and combinational strobes.
  logic [3:0] mode;
  cpw_pkg::cpw_func_type func;
  logic [9:0] duty_next;
  logic wr_fire, wr_low, wr_high, wr_ctrl, wr_flags, cap_level_d, rise, fall, cap_event;
  logic match, match_new, period_end, duty_hit;
  assign mode = control_q[`CPW_CTRL_MODE_MSB:0];

  // Decode the mode field into a function class.
  always_comb begin
    unique case (mode)
      `CPW_MODE_OFF: func = cpw_pkg::CPW_FN_OFF; // RULE1
      `CPW_MODE_CMP_TOGGLE, `CPW_MODE_CMP_SET, `CPW_MODE_CMP_CLEAR,
      `CPW_MODE_CMP_SOFT, `CPW_MODE_CMP_SPECIAL: func = cpw_pkg::CPW_FN_COMPARE;
      `CPW_MODE_CAP_FALL, `CPW_MODE_CAP_RISE, `CPW_MODE_CAP_RISE4,
      `CPW_MODE_CAP_RISE16: func = cpw_pkg::CPW_FN_CAPTURE;
      4'hC, 4'hD, 4'hE, 4'hF: func = cpw_pkg::CPW_FN_PWM; // RULE6
      default: func = cpw_pkg::CPW_FN_RESERVED; // RULE1
    endcase
  end

  // Register write strobes once address and data are both held.
  assign wr_fire = aw_have_q && w_have_q && !bvalid_q && wstrb0_q;
  assign wr_low = wr_fire && awaddr_q == `CPW_ADDR_RES_LOW;
  assign wr_high = wr_fire && awaddr_q == `CPW_ADDR_RES_HIGH && func != cpw_pkg::CPW_FN_PWM;
  assign wr_ctrl = wr_fire && awaddr_q == `CPW_ADDR_CONTROL;
  assign wr_flags = wr_fire && awaddr_q == `CPW_ADDR_FLAGS;

  // Write address channel: one held address at a time.
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      aw_have_q <= 1'b0;
      awaddr_q <= 12'h000;
      awready_q <= 1'b0;
    end else if (s_axi_awvalid_in && awready_q) begin
      aw_have_q <= 1'b1;
      awaddr_q <= {s_axi_awaddr_in[11:2], 2'h0};
      awready_q <= 1'b0;
    end else if (bvalid_q && s_axi_bready_in) begin
      aw_have_q <= 1'b0;
      awready_q <= 1'b1;
    end else begin
      awready_q <= !aw_have_q;
    end
  end

  // Write data channel, accepted independently of the address.
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      w_have_q <= 1'b0;
      wdata_q <= 32'h0000_0000;
      wstrb0_q <= 1'b0;
      wready_q <= 1'b0;
    end else if (s_axi_wvalid_in && wready_q) begin
      w_have_q <= 1'b1;
      wdata_q <= s_axi_wdata_in;
      wstrb0_q <= s_axi_wstrb_in[0];
      wready_q <= 1'b0;
    end else if (bvalid_q && s_axi_bready_in) begin
      w_have_q <= 1'b0;
      wready_q <= 1'b1;
    end else begin
      wready_q <= !w_have_q;
    end
  end

  // Write response follows both halves; unmapped addresses answer an error.
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      bvalid_q <= 1'b0;
      bresp_q <= `CPW_RESP_OKAY;
    end else if (bvalid_q) begin
      if (s_axi_bready_in) begin
        bvalid_q <= 1'b0;
      end
    end else if (aw_have_q && w_have_q) begin
      bvalid_q <= 1'b1;
      if (awaddr_q == `CPW_ADDR_RES_LOW || awaddr_q == `CPW_ADDR_RES_HIGH ||
          awaddr_q == `CPW_ADDR_CONTROL || awaddr_q == `CPW_ADDR_FLAGS) begin
        bresp_q <= `CPW_RESP_OKAY;
      end else begin
        bresp_q <= `CPW_RESP_SLVERR;
      end
    end
  end

  // Read channel: the answer comes one cycle after the address is taken.
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= `CPW_RESP_OKAY;
    end else if (s_axi_arvalid_in && arready_q) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b1;
      rresp_q <= `CPW_RESP_OKAY;
      unique case ({s_axi_araddr_in[11:2], 2'h0})
        `CPW_ADDR_RES_LOW: rdata_q <= {24'h000000, res_low_q};
        `CPW_ADDR_RES_HIGH: rdata_q <= {24'h000000, res_high_q};
        `CPW_ADDR_CONTROL: rdata_q <= {26'h0000000, control_q}; // RULE22
        `CPW_ADDR_FLAGS: rdata_q <= {26'h0000000, unit_flag_q, 4'h0, t1_ovf_flag_q};
        default: begin
          rdata_q <= 32'h0000_0000;
          rresp_q <= `CPW_RESP_SLVERR;
        end
      endcase
    end else if (rvalid_q) begin
      if (s_axi_rready_in) begin
        rvalid_q <= 1'b0;
        arready_q <= 1'b1;
      end
    end else begin
      arready_q <= 1'b1;
    end
  end

  // Control register; bits 7:6 are not stored.
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      control_q <= 6'(`CPW_CONTROL_RST);
    end else if (wr_ctrl) begin
      control_q <= wdata_q[`CPW_CTRL_DUTY_MSB:0]; // RULE21
    end
  end

  // Pin synchroniser; the level counts once the second and third stages agree.
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      sync3_q <= 1'b0;
      pin_filt_q <= 1'b0;
    end else begin
      sync1_q <= unit_pin_in;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      if (sync2_q == sync3_q) begin
        pin_filt_q <= sync3_q; // RULE25
      end
    end
  end

  // A driven pin shows the port latch, so port writes act as pin edges.
  assign cap_level_d = port_direction_in ? pin_filt_q : port_data_in; // RULE10
  assign rise = cap_level_d && !cap_level_q; // RULE25
  assign fall = !cap_level_d && cap_level_q;

  // Edge prescaler counts rising edges in any capture mode.
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in || func != cpw_pkg::CPW_FN_CAPTURE) begin
      presc_q <= 4'h0; // RULE11
    end else if (rise) begin
      presc_q <= presc_q + 4'h1; // RULE12
    end
  end

  // Capture event selection by mode.
  always_comb begin
    cap_event = 1'b0;
    if (func == cpw_pkg::CPW_FN_CAPTURE) begin
      unique case (mode)
        `CPW_MODE_CAP_FALL: cap_event = fall; // RULE2
        `CPW_MODE_CAP_RISE: cap_event = rise; // RULE2
        `CPW_MODE_CAP_RISE4: cap_event = rise && presc_q[1:0] == 2'h3; // RULE2
        default: cap_event = rise && presc_q == 4'hF; // RULE2
      endcase
    end
  end

  // Compare: equality is checked each cycle, acted on when it first appears.
  assign match = func == cpw_pkg::CPW_FN_COMPARE
                 && {res_high_q, res_low_q} == timer_one_in; // RULE13
  assign match_new = match && !match_q;

  // Edge history of the capture source and of the compare equality.
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      cap_level_q <= 1'b0;
      match_q <= 1'b0;
    end else begin
      cap_level_q <= cap_level_d;
      match_q <= match;
    end
  end

  // Pulse-width period end and duty comparison.
  assign period_end = func == cpw_pkg::CPW_FN_PWM && timer_two_tick_in
                      && timer_two_in == period_register_in; // RULE23
  assign duty_next = {res_low_q, control_q[`CPW_CTRL_DUTY_MSB:`CPW_CTRL_DUTY_LSB]};
  assign duty_hit = {res_high_q, duty_lsb_latch_q}
                    == {timer_two_in, timer_two_phase_in}; // RULE24

  // Result low byte: capture wins over a software write in the same cycle.
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      res_low_q <= `CPW_RESULT_RST;
    end else if (cap_event) begin
      res_low_q <= timer_one_in[7:0]; // RULE7 RULE9
    end else if (wr_low) begin
      res_low_q <= wdata_q[7:0];
    end
  end

  // Result high byte: capture, duty reload at period end, or software.
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      res_high_q <= `CPW_RESULT_RST;
      duty_lsb_latch_q <= 2'h0;
    end else if (cap_event) begin
      res_high_q <= timer_one_in[15:8]; // RULE7 RULE9
    end else if (period_end) begin
      res_high_q <= res_low_q; // RULE23
      duty_lsb_latch_q <= control_q[`CPW_CTRL_DUTY_MSB:`CPW_CTRL_DUTY_LSB]; // RULE21
    end else if (wr_high) begin
      res_high_q <= wdata_q[7:0];
    end
  end

  // Unit flag: hardware sets, software clears by writing zero; set wins.
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      unit_flag_q <= 1'b0;
    end else if (cap_event || match_new) begin
      unit_flag_q <= 1'b1; // RULE8 RULE3 RULE4 RULE5 RULE13
    end else if (wr_flags) begin
      unit_flag_q <= wdata_q[`CPW_FLAG_UNIT_BIT] && unit_flag_q; // RULE8
    end
  end

  // Overflow flag comes only from the timer's own overflow, never the trigger.
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      t1_ovf_flag_q <= 1'b0;
    end else if (timer_one_overflow_in) begin
      t1_ovf_flag_q <= 1'b1; // RULE16
    end else if (wr_flags) begin
      t1_ovf_flag_q <= wdata_q[`CPW_FLAG_T1OVF_BIT] && t1_ovf_flag_q;
    end
  end

  // Special event: trigger at once, timer reset at the next timer-one edge.
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      special_q <= 1'b0;
      adc_start_q <= 1'b0;
      pending_reset_q <= 1'b0;
      t1_reset_q <= 1'b0;
    end else begin
      special_q <= match_new && mode == `CPW_MODE_CMP_SPECIAL; // RULE15
      adc_start_q <= match_new && mode == `CPW_MODE_CMP_SPECIAL
                     && adc_enabled_in; // RULE5
      t1_reset_q <= 1'b0;
      if (!match || mode != `CPW_MODE_CMP_SPECIAL) begin
        pending_reset_q <= 1'b0; // RULE17
      end else if (match_new) begin
        pending_reset_q <= 1'b1; // RULE5
      end else if (pending_reset_q && timer_one_tick_in) begin
        pending_reset_q <= 1'b0;
        t1_reset_q <= 1'b1; // RULE15
      end
    end
  end

  // Compare output latch, forced low while the unit is off.
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in || func == cpw_pkg::CPW_FN_OFF) begin
      cmp_latch_q <= 1'b0; // RULE14 RULE1
    end else if (match_new) begin
      unique case (mode)
        `CPW_MODE_CMP_TOGGLE: cmp_latch_q <= !cmp_latch_q; // RULE3
        `CPW_MODE_CMP_SET: cmp_latch_q <= 1'b1; // RULE3
        `CPW_MODE_CMP_CLEAR: cmp_latch_q <= 1'b0; // RULE3
        default: cmp_latch_q <= cmp_latch_q; // RULE4 RULE5
      endcase
    end
  end

  // Pulse latch: set at period end unless duty is zero, cleared on duty match.
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in || func == cpw_pkg::CPW_FN_OFF) begin
      pwm_latch_q <= 1'b0; // RULE20 RULE1
    end else if (period_end) begin
      pwm_latch_q <= duty_next != 10'h000; // RULE23 RULE19
    end else if (func == cpw_pkg::CPW_FN_PWM && duty_hit) begin
      pwm_latch_q <= 1'b0; // RULE24
    end
  end

  // Pin drive: the unit sets the pin level in compare and pulse modes; the port direction sets the enable.
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      pin_out_q <= 1'b0;
      pin_oe_n_q <= 1'b1;
    end else begin
      pin_oe_n_q <= port_direction_in;
      unique case (func)
        cpw_pkg::CPW_FN_COMPARE: pin_out_q <= cmp_latch_q; // RULE3
        cpw_pkg::CPW_FN_PWM: pin_out_q <= pwm_latch_q ^ mode[1]; // RULE6
        default: pin_out_q <= port_data_in; // RULE20
      endcase
    end
  end
  assign s_axi_awready_out = awready_q;
  assign s_axi_wready_out = wready_q;
  assign s_axi_bvalid_out = bvalid_q;
  assign s_axi_bresp_out = bresp_q;
  assign s_axi_arready_out = arready_q;
  assign s_axi_rvalid_out = rvalid_q;
  assign s_axi_rdata_out = rdata_q;
  assign s_axi_rresp_out = rresp_q;
  assign timer_one_reset_out = t1_reset_q;
  assign adc_start_out = adc_start_q;
  assign special_event_out = special_q;
  assign unit_pin_out = pin_out_q;
  assign unit_pin_oe_n_out = pin_oe_n_q;
  assign unit_flag_out = unit_flag_q;
endmodule

//--- core/cpw_defines.svh
// Register offsets, field positions, reset values and mode codes of the unit.
`ifndef CPW_DEFINES_SVH
`define CPW_DEFINES_SVH

// Register indices as printed; the bus byte address is four times the index.
`define CPW_IDX_FLAGS 8'h0C
`define CPW_IDX_RES_LOW 8'h13
`define CPW_IDX_RES_HIGH 8'h14
`define CPW_IDX_CONTROL 8'h15
`define CPW_ADDR_FLAGS 12'h030
`define CPW_ADDR_RES_LOW 12'h04C
`define CPW_ADDR_RES_HIGH 12'h050
`define CPW_ADDR_CONTROL 12'h054

// Field positions.
`define CPW_FLAG_UNIT_BIT 5
`define CPW_FLAG_T1OVF_BIT 0
`define CPW_CTRL_DUTY_MSB 5
`define CPW_CTRL_DUTY_LSB 4
`define CPW_CTRL_MODE_MSB 3

// Reset values.
`define CPW_CONTROL_RST 8'h00
`define CPW_RESULT_RST 8'h00

// Mode field codes.
`define CPW_MODE_OFF 4'h0
`define CPW_MODE_CMP_TOGGLE 4'h2
`define CPW_MODE_CAP_FALL 4'h4
`define CPW_MODE_CAP_RISE 4'h5
`define CPW_MODE_CAP_RISE4 4'h6
`define CPW_MODE_CAP_RISE16 4'h7
`define CPW_MODE_CMP_SET 4'h8
`define CPW_MODE_CMP_CLEAR 4'h9
`define CPW_MODE_CMP_SOFT 4'hA
`define CPW_MODE_CMP_SPECIAL 4'hB

// Bus responses.
`define CPW_RESP_OKAY 2'h0
`define CPW_RESP_SLVERR 2'h2

`endif

//--- core/cpw_pkg.sv
// Types shared by the capture, compare and pulse-width unit.
package cpw_pkg;

  // Function class decoded from the mode field.
  typedef enum logic [2:0] {
    CPW_FN_OFF,
    CPW_FN_RESERVED,
    CPW_FN_CAPTURE,
    CPW_FN_COMPARE,
    CPW_FN_PWM
  } cpw_func_type;

endpackage

//--- sim/cpw_unit_properties.sv
// Concurrent checks on the ports of the capture, compare and pulse-width unit.
module cpw_unit_checker (
  input wire logic ref_clk_in,
  input wire logic sys_rst_in,
  input wire logic s_axi_wvalid_in,
  input wire logic timer_one_tick_in,
  input wire logic timer_one_reset_out,
  input wire logic adc_enabled_in,
  input wire logic adc_start_out,
  input wire logic special_event_out,
  input wire logic port_direction_in,
  input wire logic unit_pin_out,
  input wire logic unit_pin_oe_n_out,
  input wire logic unit_flag_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (sys_rst_in);

  // A trigger is a single pulse, and so is the timer clear.
  sequence s_one_trigger;
    special_event_out ##1 !special_event_out;
  endsequence
  sequence s_one_clear;
    timer_one_reset_out ##1 !timer_one_reset_out;
  endsequence

  // Trigger, conversion start, flag and pin relations.
  AST_TRIGGER_ONCE: assert property (special_event_out |-> s_one_trigger)
    else $error("special trigger lasted more than one cycle");
  AST_ADC_WITH_TRIGGER: assert property (adc_start_out == (special_event_out && $past(adc_enabled_in)))
    else $error("conversion start does not match trigger and enable");
  AST_FLAG_WITH_TRIGGER: assert property (special_event_out |-> ##[0:1] unit_flag_out)
    else $error("trigger without unit flag");
  AST_PIN_KEPT_ON_TRIGGER: assert property (special_event_out |=> $stable(unit_pin_out))
    else $error("pin moved on special trigger");
  AST_CLEAR_AFTER_TICK: assert property (timer_one_reset_out |-> $past(timer_one_tick_in))
    else $error("timer clear without a timer tick");
  AST_CLEAR_ONCE: assert property (timer_one_reset_out |-> s_one_clear)
    else $error("timer clear lasted more than one cycle");
  AST_FLAG_STICKY: assert property (unit_flag_out && !s_axi_wvalid_in && !$past(s_axi_wvalid_in) |=> unit_flag_out)
    else $error("unit flag cleared without a write");
  AST_PIN_DIRECTION: assert property (!$past(sys_rst_in) |-> unit_pin_oe_n_out == $past(port_direction_in))
    else $error("pin enable does not follow port direction");
  AST_RESET_STATE: assert property ($fell(sys_rst_in) |-> !unit_pin_out && unit_pin_oe_n_out && !unit_flag_out && !special_event_out)
    else $error("outputs not idle after reset");
endmodule

bind cpw_unit cpw_unit_checker u_checker (.*);

//--- sim/cpw_pin_model.sv
// Model of the outside circuit on the unit pin.
module cpw_pin_model (
  input wire logic ext_level_in,
  input wire logic unit_pin_out,
  input wire logic unit_pin_oe_n_out,
  output logic pin_level_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // The outside source drives only while the unit leaves the pin as input.
  assign pin_level_out = unit_pin_oe_n_out ? ext_level_in : unit_pin_out;
endmodule

//--- sim/capture_compare_pwm_unit_test.sv
// Self-checking bench for the capture, compare and pulse-width unit.
`include "cpw_defines.svh"
module capture_compare_pwm_unit_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk_in, sys_rst_in, s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in;
  logic s_axi_arvalid_in, s_axi_rready_in, s_axi_awready_out, s_axi_wready_out;
  logic s_axi_bvalid_out, s_axi_arready_out, s_axi_rvalid_out;
  logic [11:0] s_axi_awaddr_in, s_axi_araddr_in;
  logic [31:0] s_axi_wdata_in, s_axi_rdata_out, rd;
  logic [3:0] s_axi_wstrb_in;
  logic [1:0] s_axi_bresp_out, s_axi_rresp_out, timer_two_phase_in;
  logic [15:0] timer_one_in;
  logic [7:0] timer_two_in, period_register_in;
  logic timer_one_tick_in, timer_one_overflow_in, timer_one_reset_out, timer_two_tick_in;
  logic adc_enabled_in, adc_start_out, special_event_out, port_direction_in, port_data_in;
  logic unit_pin_in, unit_pin_out, unit_pin_oe_n_out, unit_flag_out, ext, pwm_run;
  int fail_count = 0, check_count = 0, n_spec = 0, n_clr = 0, n_adc = 0;

  cpw_unit u_dut (.*);
  cpw_pin_model u_pin (.ext_level_in(ext), .unit_pin_out, .unit_pin_oe_n_out,
    .pin_level_out(unit_pin_in));

  // The clock toggles every 5 ns, a period of 10 ns.
  initial begin
    ref_clk_in = 1'b0;
    forever #5 ref_clk_in = ~ref_clk_in;
  end

  // Timer two counts four phases per tick and wraps at the period value.
  always @(posedge ref_clk_in) begin
    if (pwm_run) begin
      timer_two_phase_in <= timer_two_phase_in + 2'h1;
      timer_two_tick_in <= (timer_two_phase_in == 2'h2);
      if (timer_two_tick_in) timer_two_in <= (timer_two_in == period_register_in) ? 8'h00 : timer_two_in + 8'h01;
    end
  end

  // Counts of the one-cycle pulses that the unit gives out.
  always @(posedge ref_clk_in) begin
    n_spec <= n_spec + int'(special_event_out);
    n_clr <= n_clr + int'(timer_one_reset_out);
    n_adc <= n_adc + int'(adc_start_out);
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic end_sim;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic timed_out(input int n);
    if (n >= 50) begin
      fail_count++;
      end_sim();
    end
  endtask

  // A write offers address and data together and holds each until it is taken.
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge ref_clk_in);
    s_axi_awaddr_in <= a;
    s_axi_wdata_in <= {24'h000000, d};
    s_axi_awvalid_in <= 1'b1;
    s_axi_wvalid_in <= 1'b1;
    s_axi_bready_in <= 1'b1;
    do begin
      @(posedge ref_clk_in);
      if (s_axi_awready_out) s_axi_awvalid_in <= 1'b0;
      if (s_axi_wready_out) s_axi_wvalid_in <= 1'b0;
      n++;
    end while (!s_axi_bvalid_out && n < 50);
    s_axi_bready_in <= 1'b0;
    timed_out(n);
  endtask

  // A read returns the data word in rd and compares the response code.
  task automatic rdr(input logic [11:0] a, input logic [1:0] resp);
    int n;
    n = 0;
    @(posedge ref_clk_in);
    s_axi_araddr_in <= a;
    s_axi_arvalid_in <= 1'b1;
    s_axi_rready_in <= 1'b1;
    do begin
      @(posedge ref_clk_in);
      if (s_axi_arready_out) s_axi_arvalid_in <= 1'b0;
      n++;
    end while (!s_axi_rvalid_out && n < 50);
    rd = s_axi_rdata_out;
    check(s_axi_rresp_out, resp);
    s_axi_rready_in <= 1'b0;
    timed_out(n);
  endtask

  task automatic edge_to(input logic lv);
    @(posedge ref_clk_in);
    ext <= lv;
    repeat (8) @(posedge ref_clk_in);
  endtask

  task automatic pulses(input int n);
    repeat (n) begin
      edge_to(1'b0);
      edge_to(1'b1);
    end
  endtask

  task automatic set_mode(input logic [7:0] m);
    wr(`CPW_ADDR_CONTROL, `CPW_CONTROL_RST);
    wr(`CPW_ADDR_CONTROL, m);
    wr(`CPW_ADDR_FLAGS, 8'h00);
  endtask

  task automatic test_regs;
    rdr(`CPW_ADDR_CONTROL, `CPW_RESP_OKAY);
    check(rd, 32'h00000000);
    wr(`CPW_ADDR_CONTROL, 8'hFF);
    rdr(`CPW_ADDR_CONTROL, `CPW_RESP_OKAY);
    check(rd, 32'h0000003F);
    wr(`CPW_ADDR_CONTROL, 8'h00);
    rdr(12'h0FC, `CPW_RESP_SLVERR);
    check(rd, 32'h00000000);
    $display("register test done");
  endtask

  task automatic test_capture;
    timer_one_in <= 16'h1234;
    set_mode(8'h05);
    edge_to(1'b1);
    check(unit_flag_out, 1'b1);
    timer_one_in <= 16'hBEEF;
    pulses(1);
    rdr(`CPW_ADDR_RES_LOW, `CPW_RESP_OKAY);
    check(rd, 32'h000000EF);
    rdr(`CPW_ADDR_RES_HIGH, `CPW_RESP_OKAY);
    check(rd, 32'h000000BE);
    check(unit_flag_out, 1'b1);
    set_mode(8'h04);
    edge_to(1'b0);
    check(unit_flag_out, 1'b1);
    wr(`CPW_ADDR_FLAGS, 8'h00);
    edge_to(1'b1);
    check(unit_flag_out, 1'b0);
    set_mode(8'h06);
    pulses(3);
    check(unit_flag_out, 1'b0);
    pulses(1);
    check(unit_flag_out, 1'b1);
    set_mode(8'h06);
    pulses(2);
    wr(`CPW_ADDR_CONTROL, 8'h07);
    wr(`CPW_ADDR_FLAGS, 8'h00);
    pulses(13);
    check(unit_flag_out, 1'b0);
    pulses(1);
    check(unit_flag_out, 1'b1);
    set_mode(8'h05);
    port_direction_in <= 1'b0;
    repeat (4) @(posedge ref_clk_in);
    port_data_in <= 1'b1;
    repeat (8) @(posedge ref_clk_in);
    check(unit_flag_out, 1'b1);
    port_data_in <= 1'b0;
    $display("capture test done");
  endtask

  task automatic test_compare;
    logic [3:0] modes [6] = '{4'h1, 4'h3, 4'h8, 4'hA, 4'h9, 4'h2};
    logic pins [6] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1};
    logic flags [6] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1};
    timer_one_in <= 16'h0000;
    wr(`CPW_ADDR_CONTROL, 8'h00);
    wr(`CPW_ADDR_RES_LOW, 8'h00);
    wr(`CPW_ADDR_RES_HIGH, 8'h01);
    for (int i = 0; i < 6; i++) begin
      wr(`CPW_ADDR_CONTROL, {4'h0, modes[i]});
      wr(`CPW_ADDR_FLAGS, 8'h00);
      timer_one_in <= 16'h0100;
      repeat (3) @(posedge ref_clk_in);
      timer_one_in <= 16'h0000;
      repeat (3) @(posedge ref_clk_in);
      check(unit_pin_out, pins[i]);
      check(unit_flag_out, flags[i]);
    end
    wr(`CPW_ADDR_CONTROL, 8'h00);
    wr(`CPW_ADDR_CONTROL, 8'h0A);
    repeat (3) @(posedge ref_clk_in);
    check(unit_pin_out, 1'b0);
    $display("compare test done");
  endtask

  task automatic test_special;
    int s, c, a;
    s = n_spec;
    c = n_clr;
    a = n_adc;
    adc_enabled_in <= 1'b1;
    set_mode(8'h0B);
    timer_one_in <= 16'h0100;
    repeat (4) @(posedge ref_clk_in);
    check(n_spec - s, 1);
    check(n_adc - a, 1);
    check(n_clr - c, 0);
    timer_one_tick_in <= 1'b1;
    @(posedge ref_clk_in);
    timer_one_tick_in <= 1'b0;
    repeat (3) @(posedge ref_clk_in);
    check(n_clr - c, 1);
    rdr(`CPW_ADDR_FLAGS, `CPW_RESP_OKAY);
    check(rd, 32'h00000020);
    timer_one_in <= 16'h0000;
    repeat (3) @(posedge ref_clk_in);
    timer_one_in <= 16'h0100;
    repeat (3) @(posedge ref_clk_in);
    timer_one_in <= 16'h0101;
    timer_one_tick_in <= 1'b1;
    @(posedge ref_clk_in);
    timer_one_tick_in <= 1'b0;
    repeat (3) @(posedge ref_clk_in);
    check(n_clr - c, 1);
    $display("special trigger test done");
  endtask

  // Counts pin-high cycles over four periods of sixteen cycles.
  task automatic high_count(input logic [7:0] ctl, input logic [7:0] duty, output int n);
    wr(`CPW_ADDR_RES_LOW, duty);
    wr(`CPW_ADDR_CONTROL, ctl);
    repeat (40) @(posedge ref_clk_in);
    n = 0;
    repeat (64) begin
      @(posedge ref_clk_in);
      n += int'(unit_pin_out);
    end
  endtask

  task automatic test_pwm;
    int h4, h5, h8, hl, h0;
    port_direction_in <= 1'b0;
    period_register_in <= 8'h03;
    pwm_run <= 1'b1;
    high_count(8'h0C, 8'h01, h4);
    high_count(8'h1C, 8'h01, h5);
    high_count(8'h0C, 8'h02, h8);
    high_count(8'h0E, 8'h02, hl);
    high_count(8'h0C, 8'h00, h0);
    check(h5 - h4, 4);
    check(h8 - h4, 16);
    check(hl + h8, 64);
    check(h0, 0);
    $display("pulse-width test done");
  endtask

  // Inputs settle at time zero, reset is held four cycles, then the tests run.
  initial begin
    {s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in, s_axi_arvalid_in} = 4'h0;
    {s_axi_rready_in, timer_one_tick_in, timer_one_overflow_in, adc_enabled_in} = 4'h0;
    {timer_two_tick_in, port_data_in, ext, pwm_run} = 4'h0;
    s_axi_awaddr_in = 12'h000;
    s_axi_araddr_in = 12'h000;
    s_axi_wdata_in = 32'h00000000;
    s_axi_wstrb_in = 4'hF;
    timer_one_in = 16'h0000;
    timer_two_in = 8'h00;
    timer_two_phase_in = 2'h0;
    period_register_in = 8'hFF;
    port_direction_in = 1'b1;
    sys_rst_in = 1'b1;
    repeat (4) @(posedge ref_clk_in);
    sys_rst_in <= 1'b0;
    @(posedge ref_clk_in);
    test_regs();
    test_capture();
    test_compare();
    test_special();
    test_pwm();
    end_sim();
  end
endmodule
